// ==== nvpe_dev.sv ====
// Nonvolatile array end: control register, latches, erase/program engine.
// Assumes the far end sequences control writes as documented.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "nvpe_cfg.svh"
module nvpe_dev (
   // Clock and reset
   input  wire logic   clk,
   input  wire logic   arst_n,
   // Internal bus
   nvpe_bus_if.dev     bus,
   // Device straps
   input  wire logic   special_mode,
   input  wire logic   secure_fuse,
   // Status
   output logic        high_voltage_on,
   output logic        otp_bus_program,
   output logic [7:0]  option_value
);
   import nvpe_pkg::*;
   localparam int AW = $clog2(`NVPE_ARR_SIZE);
   logic [7:0]  mem_q [`NVPE_ARR_SIZE];
   logic [7:0]  opt_q;
   logic [7:0]  ctrl_q;
   logic [7:0]  rdata_q;
   logic        cap_q;
   logic [15:0] cap_addr_q;
   logic [7:0]  cap_data_q;
   logic [4:0]  guard;

   ////////////////////////////////////////////////////////////////
   // Decode
   wire ctrl_hit  = bus.addr == `NVPE_CTRL_ADDR;
   wire guard_hit = bus.addr == `NVPE_GUARD_ADDR;
   wire opt_hit   = bus.addr == `NVPE_OPT_ADDR;
   wire arr_hit   = bus.addr >= `NVPE_ARR_BASE && bus.addr < 16'(`NVPE_ARR_BASE + `NVPE_ARR_SIZE);
   wire [AW-1:0] arr_idx = AW'(bus.addr - `NVPE_ARR_BASE);
   wire latch     = ctrl_q[`NVPE_BIT_LATCH];
   wire volt      = ctrl_q[`NVPE_BIT_VOLT];
   wire otplat    = ctrl_q[`NVPE_BIT_OTPLAT];

   function automatic logic [1:0] region_of(input logic [AW-1:0] i);
      if (i < AW'(32)) return 2'd0;
      else if (i < AW'(96)) return 2'd1;
      else if (i < AW'(224)) return 2'd2;
      else return 2'd3;
   endfunction

   ////////////////////////////////////////////////////////////////
   // Control register write
   wire [7:0] w = bus.wdata;
   wire both_new = w[`NVPE_BIT_LATCH] & w[`NVPE_BIT_VOLT] & ~volt & ~latch;
   wire volt_ok  = latch | otplat;
   logic [7:0] ctrl_d;
   always_comb begin
      ctrl_d = {2'b00, w[5:0]};
      if (!volt_ok) ctrl_d[`NVPE_BIT_VOLT] = 1'b0;
      if (both_new) begin
         ctrl_d[`NVPE_BIT_VOLT]  = 1'b0;
         ctrl_d[`NVPE_BIT_LATCH] = 1'b0;
      end
      if (ctrl_d[`NVPE_BIT_LATCH] && ctrl_d[`NVPE_BIT_OTPLAT])
         ctrl_d[`NVPE_BIT_OTPLAT] = 1'b0;
      if (volt && (ctrl_d[`NVPE_BIT_OTPLAT] != otplat) && (w != 8'h00))
         ctrl_d[`NVPE_BIT_OTPLAT] = otplat;
   end
   wire ctrl_wr = bus.wr & ctrl_hit;

   ////////////////////////////////////////////////////////////////
   // Operation applied on voltage falling edge
   wire hv_end = ctrl_wr & volt & ~ctrl_d[`NVPE_BIT_VOLT];
   wire erase  = ctrl_q[`NVPE_BIT_ERASE];
   nvpe_op_t op;
   always_comb begin
      if (!erase) op = NVPE_OP_PROGRAM;
      else if (ctrl_q[`NVPE_BIT_BYTE]) op = NVPE_OP_BYTE;
      else if (ctrl_q[`NVPE_BIT_ROW]) op = NVPE_OP_ROW;
      else op = NVPE_OP_BULK;
   end
   wire cap_opt = cap_addr_q == `NVPE_OPT_ADDR;
   wire [AW-1:0] cap_idx = AW'(cap_addr_q - `NVPE_ARR_BASE);
   wire apply = hv_end & latch & cap_q;

   always_ff @(posedge clk) begin
      if (apply && !cap_opt) begin
         for (int i = 0; i < `NVPE_ARR_SIZE; i++) begin
            if (!guard[region_of(AW'(i))]) begin
               unique case (op)
                  NVPE_OP_PROGRAM: if (AW'(i) == cap_idx) mem_q[i] <= mem_q[i] & cap_data_q;
                  NVPE_OP_BULK:    mem_q[i] <= 8'hFF;
                  NVPE_OP_ROW:     if (AW'(i) >> 4 == cap_idx >> 4) mem_q[i] <= 8'hFF;
                  NVPE_OP_BYTE:    if (AW'(i) == cap_idx) mem_q[i] <= 8'hFF;
                  default:         ;
               endcase
            end
         end
      end
   end

   // Option cells follow the program, row erase and byte erase sequences at their own address
   // Nonvolatile: a reset keeps the programmed value
   always_ff @(posedge clk) begin
      if (apply && cap_opt && !guard[4]) begin
         if (op == NVPE_OP_PROGRAM) opt_q <= opt_q & cap_data_q;
         else if (op == NVPE_OP_BYTE || op == NVPE_OP_ROW) opt_q <= 8'hFF;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Control, capture, read data
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) ctrl_q <= `NVPE_CTRL_RESET;
      else if (ctrl_wr) ctrl_q <= ctrl_d;
   end
   wire cap_take = bus.wr & latch & ~volt & (arr_hit | opt_hit);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cap_q      <= 1'b0;
         cap_addr_q <= 16'h0000;
         cap_data_q <= 8'h00;
      end else if (!latch) begin
         cap_q <= 1'b0;
      end else if (cap_take) begin
         cap_q      <= 1'b1;
         cap_addr_q <= bus.addr;
         cap_data_q <= bus.wdata;
      end
   end
   // Array reads blocked while latched
   wire [7:0] rd_mux = ctrl_hit ? ctrl_q :
                       guard_hit ? {3'b000, guard} :
                       opt_hit ? opt_q :
                       (arr_hit && !latch) ? mem_q[arr_idx] : 8'h00;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) rdata_q <= 8'h00;
      else if (bus.rd) rdata_q <= rd_mux;
   end
   assign bus.rdata = rdata_q;
   assign bus.secure = secure_fuse;
   assign high_voltage_on = volt;
   assign otp_bus_program = otplat;
   assign option_value = opt_q;

   nvpe_guard u_guard (
      .clk          (clk),
      .arst_n       (arst_n),
      .wr           (bus.wr & guard_hit),
      .wdata        (bus.wdata[4:0]),
      .special_mode (special_mode),
      .guard        (guard)
   );
endmodule

// ==== nvpe_cfg.svh ====
// Constants for the nonvolatile program/erase controller pair.
// Assumes inclusion by bare name from package and design files.
//
// Summary of operation
// - Byte beats row; neither means whole array
// - Erase bit picks erase over program
// - Latch clear: reads normal, no alteration
// - Latch set: array paths dedicated, reads blocked
// - Voltage bit switches high voltage on/off
// - Row and byte bits ignored when programming
// - Slow clock needs internal pump oscillator
// - Programming only clears bits; erase first
// - Program: latch, data write, voltage, wait
// - Bulk erase: latch+erase, write, voltage, wait
// - Row erase: row+erase+latch, write, voltage
// - Byte erase: byte+erase+latch, write, voltage
// - Writing zero ends operation, normal reads
// - Bulk erase spares option register
// - Option register handled like array byte
// - Option change: erase, program, then reset
// - Two latch bits exclusive; one voltage bit; code keeps otp latch if latch is set while voltage is on, both then set
// - Otp latch configures otp bus for programming
// - Secure part stays in single-chip modes
// - Latch and voltage together: neither sets
// - Voltage bit writable only with latch set; code also allows it while only the otp latch is set
// - Guard bits reset set; clear in 64 cycles
`ifndef NVPE_CFG_SVH
`define NVPE_CFG_SVH
`define NVPE_CTRL_ADDR      16'h103B
`define NVPE_CTRL_RESET     8'h00
`define NVPE_BIT_VOLT       0
`define NVPE_BIT_LATCH      1
`define NVPE_BIT_ERASE      2
`define NVPE_BIT_ROW        3
`define NVPE_BIT_BYTE       4
`define NVPE_BIT_OTPLAT     5
`define NVPE_ARR_BASE       16'hB600
`define NVPE_ARR_SIZE       512
`define NVPE_OPT_ADDR       16'h103F
`define NVPE_ROW_BYTES      16
`define NVPE_GUARD_ADDR     16'h1035
`define NVPE_GUARD_RESET    5'h1F
`define NVPE_GUARD_WINDOW   64
`define NVPE_OPT_RESET      8'hFF
`define NVPE_CLK_MHZ        100
`define NVPE_HV_TIME_MS     10
`define NVPE_HV_CYCLES      (`NVPE_HV_TIME_MS * 1000 * `NVPE_CLK_MHZ)
// Controller's own registers
`define NVPE_SW_CMD         4'h0
`define NVPE_SW_ADDR        4'h1
`define NVPE_SW_DATA        4'h2
`define NVPE_SW_STATUS      4'h3
`define NVPE_SW_RDATA       4'h4
`define NVPE_CMD_PROGRAM    3'h0
`define NVPE_CMD_BULK       3'h1
`define NVPE_CMD_ROW        3'h2
`define NVPE_CMD_BYTE       3'h3
`define NVPE_CMD_READ       3'h4
`define NVPE_CMD_GUARD      3'h5
`endif

// ==== nvpe_pkg.sv ====
// Types shared by both ends of the program/erase link.
// Assumes nvpe_cfg.svh is on the include path.
`include "nvpe_cfg.svh"
package nvpe_pkg;
   typedef logic [15:0] nvpe_addr_t;
   typedef logic [7:0]  nvpe_byte_t;
   typedef enum logic [2:0] {
      NVPE_OP_NONE,
      NVPE_OP_PROGRAM,
      NVPE_OP_BULK,
      NVPE_OP_ROW,
      NVPE_OP_BYTE
   } nvpe_op_t;
endpackage

// ==== nvpe_bus_if.sv ====
// Internal bus between the cpu-side controller and the nonvolatile block.
// Assumes one clock; a write or read is a single-cycle strobe, read data next cycle.
`timescale 1ns/1ps
interface nvpe_bus_if;
   logic [15:0] addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic [7:0]  rdata;
   logic        secure;
   modport dev (input addr, input wdata, input wr, input rd, output rdata, output secure);
   modport ctl (output addr, output wdata, output wr, output rd, input rdata, input secure);
endinterface

// ==== nvpe_guard.sv ====
// Region guard bits: set at reset, clearable only early in normal modes.
// Assumes write strobe and data come from the device bus decode.
`timescale 1ns/1ps
`include "nvpe_cfg.svh"
module nvpe_guard (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       arst_n,
   // Write port and mode
   input  wire logic       wr,
   input  wire logic [4:0] wdata,
   input  wire logic       special_mode,
   // Guard state
   output logic [4:0]      guard
);
   import nvpe_pkg::*;
   logic [6:0] cnt_q;
   logic [4:0] guard_q;
   wire        early = cnt_q < 7'(`NVPE_GUARD_WINDOW);
   wire        may_clr = early | special_mode;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) cnt_q <= 7'h00;
      else if (early) cnt_q <= cnt_q + 7'h01;
   end
   // Setting always allowed, clearing only in the window or in special mode
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) guard_q <= `NVPE_GUARD_RESET;
      else if (wr) guard_q <= may_clr ? wdata : (guard_q | wdata);
   end
   assign guard = guard_q;
endmodule

// ==== nvpe_ctl.sv ====
// CPU-side controller: runs program/erase sequences from software commands.
// Assumes the device answers reads one cycle after the strobe.
`timescale 1ns/1ps
`include "nvpe_cfg.svh"
module nvpe_ctl #(
   parameter int HV_CYCLES = `NVPE_HV_CYCLES
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // Software port
   input  wire logic [3:0]  sw_addr,
   input  wire logic [15:0] sw_wdata,
   input  wire logic        sw_wr,
   input  wire logic        sw_rd,
   output logic [15:0]      sw_rdata,
   // Internal bus
   nvpe_bus_if.ctl          bus
);
   import nvpe_pkg::*;
   typedef enum logic [2:0] {S_IDLE, S_LATCH, S_DATA, S_VOLT, S_WAIT, S_CLEAR, S_RDWAIT} nvpe_st_t;
   nvpe_st_t st_q;
   logic [2:0]  cmd_q;
   logic [15:0] addr_q;
   logic [7:0]  data_q, rd_q;
   logic [31:0] cnt_q;
   logic [15:0] sw_rdata_q;
   logic [15:0] b_addr;
   logic [7:0]  b_data;
   logic        b_wr, b_rd;

   wire busy = st_q != S_IDLE;
   wire go   = sw_wr & (sw_addr == `NVPE_SW_CMD) & ~busy;
   // Mode byte for the latch phase
   wire [7:0] mode = (cmd_q == `NVPE_CMD_BULK) ? 8'h06 :
                     (cmd_q == `NVPE_CMD_ROW)  ? 8'h0E :
                     (cmd_q == `NVPE_CMD_BYTE) ? 8'h16 : 8'h02;

   always_comb begin
      b_addr = addr_q;
      b_data = data_q;
      b_wr   = 1'b0;
      b_rd   = 1'b0;
      unique case (st_q)
         S_IDLE:   b_rd = go & (sw_wdata[2:0] == `NVPE_CMD_READ);
         S_LATCH:  begin b_addr = `NVPE_CTRL_ADDR; b_data = mode; b_wr = 1'b1; end
         S_DATA:   b_wr = 1'b1;
         S_VOLT:   begin b_addr = `NVPE_CTRL_ADDR; b_data = mode | 8'h01; b_wr = 1'b1; end
         S_WAIT:   ;
         S_CLEAR:  begin b_addr = `NVPE_CTRL_ADDR; b_data = 8'h00; b_wr = 1'b1; end
         S_RDWAIT: ;
      endcase
      if (st_q == S_IDLE && go && sw_wdata[2:0] == `NVPE_CMD_GUARD) begin
         b_addr = `NVPE_GUARD_ADDR;
         b_data = data_q;
         b_wr   = 1'b1;
      end
   end
   assign bus.addr  = b_addr;
   assign bus.wdata = b_data;
   assign bus.wr    = b_wr;
   assign bus.rd    = b_rd;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= S_IDLE;
         cmd_q <= 3'h0;
         cnt_q <= 32'h0;
         rd_q <= 8'h00;
      end else begin
         unique case (st_q)
            S_IDLE: if (go) begin
               cmd_q <= sw_wdata[2:0];
               if (sw_wdata[2:0] == `NVPE_CMD_READ) st_q <= S_RDWAIT;
               else if (sw_wdata[2:0] <= `NVPE_CMD_BYTE) st_q <= S_LATCH;
            end
            S_LATCH: st_q <= S_DATA;
            S_DATA:  st_q <= S_VOLT;
            S_VOLT:  begin st_q <= S_WAIT; cnt_q <= 32'h0; end
            S_WAIT:  begin
               cnt_q <= cnt_q + 32'h1;
               if (cnt_q >= 32'(HV_CYCLES - 1)) st_q <= S_CLEAR;
            end
            S_CLEAR: st_q <= S_IDLE;
            S_RDWAIT: begin rd_q <= bus.rdata; st_q <= S_IDLE; end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         addr_q <= 16'h0000;
         data_q <= 8'h00;
      end else if (sw_wr && !busy) begin
         if (sw_addr == `NVPE_SW_ADDR) addr_q <= sw_wdata;
         if (sw_addr == `NVPE_SW_DATA) data_q <= sw_wdata[7:0];
      end
   end

   wire [15:0] rd_mux = (sw_addr == `NVPE_SW_ADDR)   ? addr_q :
                        (sw_addr == `NVPE_SW_DATA)   ? {8'h00, data_q} :
                        (sw_addr == `NVPE_SW_STATUS) ? {14'h0, bus.secure, busy} :
                        (sw_addr == `NVPE_SW_RDATA)  ? {8'h00, rd_q} : 16'h0000;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) sw_rdata_q <= 16'h0000;
      else if (sw_rd) sw_rdata_q <= rd_mux;
      else sw_rdata_q <= 16'h0000;
   end
   assign sw_rdata = sw_rdata_q;
endmodule

// ==== nvpe_link_props.sv ====
// Checker for the bus between controller and array end.
// Assumes the signals of one nvpe_bus_if plus the array end status.
`timescale 1ns/1ps
`include "nvpe_cfg.svh"
module nvpe_link_props (
   // Clock and reset
   input wire logic        clk,
   input wire logic        arst_n,
   // Bus
   input wire logic [15:0] addr,
   input wire logic [7:0]  wdata,
   input wire logic        wr,
   input wire logic        rd,
   // Status
   input wire logic        high_voltage_on,
   input wire logic        otp_bus_program
);
   logic lat_q;
   wire  ctrl_wr = wr && addr == `NVPE_CTRL_ADDR;
   wire  zero_wr = ctrl_wr && wdata == 8'h00;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Latch as it should stand
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         lat_q <= 1'b0;
      else if (ctrl_wr)
         lat_q <= wdata[1] && (lat_q || !wdata[0]);
   end
   ////////////////////////////////////////////////////////////
   property p_volt_after_latch; ctrl_wr && wdata[0] |-> lat_q; endproperty
   a_volt_after_latch: assert property (p_volt_after_latch) else $error("voltage before latch");
   property p_volt_on; ctrl_wr && wdata[1:0] == 2'b11 && lat_q |=> high_voltage_on; endproperty
   a_volt_on: assert property (p_volt_on) else $error("voltage not on");
   property p_zero_off; zero_wr |=> !high_voltage_on && !otp_bus_program; endproperty
   a_zero_off: assert property (p_zero_off) else $error("zero write left voltage");
   property p_hv_stable; !ctrl_wr |=> $stable(high_voltage_on); endproperty
   a_hv_stable: assert property (p_hv_stable) else $error("voltage moved alone");
   property p_hv_hold; $rose(high_voltage_on) |-> !ctrl_wr [*8]; endproperty
   a_hv_hold: assert property (p_hv_hold) else $error("voltage cut short");
   property p_otp_excl; ctrl_wr && lat_q |=> !otp_bus_program; endproperty
   a_otp_excl: assert property (p_otp_excl) else $error("both latches set");
   property p_data_follows; ctrl_wr && wdata[1:0] == 2'b10 |-> ##[1:4] (wr && !ctrl_wr); endproperty
   a_data_follows: assert property (p_data_follows) else $error("no array write");
   property p_codes; ctrl_wr && wdata[0] |-> wdata inside {8'h03, 8'h07, 8'h0F, 8'h17}; endproperty
   a_codes: assert property (p_codes) else $error("bad voltage code");
   property p_clear_after; $fell(high_voltage_on) |-> $past(zero_wr); endproperty
   a_clear_after: assert property (p_clear_after) else $error("voltage off without clear");
endmodule

// ==== tb_top.sv ====
// Self-checking bench: controller and array end joined by one bus.
// Assumes a 100 MHz clock and a shortened high-voltage time.
`timescale 1ns/1ps
`include "nvpe_cfg.svh"
module tb_top;
   import nvpe_pkg::*;
   typedef struct {logic [2:0] cmd; logic [15:0] a; logic [7:0] d; logic [7:0] e;} nvpe_row_t;
   logic        clk, arst_n, special_mode, secure_fuse, sw_wr, sw_rd;
   logic        high_voltage_on, otp_bus_program;
   logic [3:0]  sw_addr;
   logic [15:0] sw_wdata, sw_rdata, v;
   logic [7:0]  option_value;
   logic [7:0]  seq_q [$];
   logic [7:0]  lat_code [4] = '{8'h02, 8'h06, 8'h0E, 8'h16};
   int          error_cnt, total_checks;
   nvpe_row_t   rows [12] = '{
      '{1, 16'hB600, 0, 0}, '{4, 16'hB7FF, 0, 8'hFF},
      '{0, 16'hB600, 8'hA5, 0}, '{4, 16'hB600, 0, 8'hA5},
      '{0, 16'hB600, 8'h0F, 0}, '{4, 16'hB600, 0, 8'h05},
      '{0, 16'hB610, 8'h3C, 0}, '{2, 16'hB605, 0, 0}, '{4, 16'hB600, 0, 8'hFF},
      '{4, 16'hB610, 0, 8'h3C}, '{3, 16'hB610, 0, 0}, '{4, 16'hB610, 0, 8'hFF}};
   nvpe_bus_if nvpe_bus_if_inst ();
   nvpe_dev nvpe_dev_inst (.clk(clk), .arst_n(arst_n), .bus(nvpe_bus_if_inst.dev), .special_mode(special_mode),
      .secure_fuse(secure_fuse), .high_voltage_on(high_voltage_on), .otp_bus_program(otp_bus_program),
      .option_value(option_value));
   nvpe_ctl #(.HV_CYCLES(20)) nvpe_ctl_inst (.clk(clk), .arst_n(arst_n), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .bus(nvpe_bus_if_inst.ctl));
   nvpe_link_props nvpe_link_props_inst (.clk(clk), .arst_n(arst_n), .addr(nvpe_bus_if_inst.addr),
      .wdata(nvpe_bus_if_inst.wdata), .wr(nvpe_bus_if_inst.wr), .rd(nvpe_bus_if_inst.rd),
      .high_voltage_on(high_voltage_on), .otp_bus_program(otp_bus_program));
   ////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Control register writes seen on the bus
   always @(posedge clk) begin
      if (nvpe_bus_if_inst.wr === 1'b1 && nvpe_bus_if_inst.addr === `NVPE_CTRL_ADDR)
         seq_q.push_back(nvpe_bus_if_inst.wdata);
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      sw_addr  <= a;
      sw_wdata <= d;
      sw_wr    <= 1'b1;
      @(posedge clk);
      sw_wr <= 1'b0;
   endtask
   task automatic sw_read(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      sw_addr <= a;
      sw_rd   <= 1'b1;
      @(posedge clk);
      sw_rd <= 1'b0;
      #1 d = sw_rdata;
   endtask
   task automatic run_op(input logic [2:0] cmd, input logic [15:0] a, input logic [7:0] d);
      logic [15:0] st;
      int          n;
      seq_q.delete();
      sw_write(`NVPE_SW_ADDR, a);
      sw_write(`NVPE_SW_DATA, {8'h00, d});
      sw_write(`NVPE_SW_CMD, {13'h0000, cmd});
      n = 0;
      do begin
         sw_read(`NVPE_SW_STATUS, st);
         n++;
      end while (st[0] !== 1'b0 && n < 200);
      chk(st[0], 1'b0, "busy");
      if (cmd <= 3'h3) begin
         chk(16'(seq_q.size()), 16'h0003, "ctrl writes");
         chk(seq_q[0], lat_code[cmd[1:0]], "latch code");
         chk(seq_q[1], lat_code[cmd[1:0]] | 8'h01, "voltage code");
         chk(seq_q[2], 8'h00, "clear code");
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end
   ////////////////////////////////////////////////////////////
   initial begin
      arst_n       = 1'b0;
      special_mode = 1'b0;
      secure_fuse  = 1'b0;
      sw_wr        = 1'b0;
      sw_rd        = 1'b0;
      sw_addr      = 4'h0;
      sw_wdata     = 16'h0000;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      // Guards cleared inside the early window
      run_op(5, 16'h0000, 8'h00);
      run_op(3, `NVPE_OPT_ADDR, 8'h00);
      chk({high_voltage_on, otp_bus_program, option_value}, 16'h00FF, "reset state");
      $display("test done: reset");
      foreach (rows[i]) begin
         run_op(rows[i].cmd, rows[i].a, rows[i].d);
         if (rows[i].cmd == 3'h4) begin
            sw_read(`NVPE_SW_RDATA, v);
            chk(v, {8'h00, rows[i].e}, "array byte");
         end
      end
      $display("test done: table");
      run_op(3, `NVPE_OPT_ADDR, 8'h00);
      chk(option_value, 8'hFF, "option erased");
      run_op(0, `NVPE_OPT_ADDR, 8'h5A);
      chk(option_value, 8'h5A, "option programmed");
      run_op(1, 16'hB600, 8'h00);
      chk(option_value, 8'h5A, "option after bulk");
      $display("test done: option");
      sw_read(4'hF, v);
      chk(v, 16'h0000, "unmapped read");
      secure_fuse <= 1'b1;
      sw_read(`NVPE_SW_STATUS, v);
      chk(v[1], 1'b1, "secure status");
      secure_fuse <= 1'b0;
      $display("test done: status");
      // Late guard clear must be refused
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (70) @(posedge clk);
      chk(option_value, 8'h5A, "option kept over reset");
      run_op(5, 16'h0000, 8'h00);
      run_op(0, 16'hB7FF, 8'h00);
      run_op(4, 16'hB7FF, 8'h00);
      sw_read(`NVPE_SW_RDATA, v);
      chk(v, 16'h00FF, "guarded byte");
      special_mode <= 1'b1;
      run_op(5, 16'h0000, 8'h00);
      run_op(0, 16'hB7FF, 8'h00);
      run_op(4, 16'hB7FF, 8'h00);
      sw_read(`NVPE_SW_RDATA, v);
      chk(v, 16'h0000, "special mode clear");
      special_mode <= 1'b0;
      $display("test done: guard window");
      end_of_test();
   end
endmodule
